// ===== inc/dprd_pkg.sv
package dprd_pkg;
    // four billing quantities: +active, -active, +reactive, -reactive
    localparam int DPRD_NCH = 4;
    localparam int DPRD_TRIM_W = 8;
    localparam int DPRD_CNT_W = 10;
    localparam int DPRD_INC_W = 4;
    localparam logic [DPRD_CNT_W-1:0] DPRD_BASE_STD = 10'h019;
    localparam logic [DPRD_CNT_W-1:0] DPRD_BASE_M7 = 10'h0fa;
    localparam logic [2:0] DPRD_MODE_HIGH_BASE = 3'h7;
    localparam logic [DPRD_CNT_W-1:0] DPRD_CNT_RST = 10'h000;
    localparam int DPRD_MC_PER_KWH = 1250;
    localparam int DPRD_ELSB_MWH = 400;
endpackage

// ===== inc/dprd_thr_if.sv
`timescale 1ns/1ps
interface dprd_thr_if;
    import dprd_pkg::*;
    logic [DPRD_TRIM_W-1:0] trim;
    logic [2:0] mode;
    logic [DPRD_CNT_W-1:0] thr;
    modport calc (input trim, input mode, output thr);
    modport user (output trim, output mode, input thr);
endinterface

// ===== logic/dprd_thr_calc.sv
`timescale 1ns/1ps
module dprd_thr_calc
    import dprd_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // trim and mode in, threshold out
    dprd_thr_if.calc thr_if
);
    logic [DPRD_CNT_W-1:0] thr_r;
    logic [DPRD_CNT_W-1:0] thr_nxt;

    // base plus trim; registered so the comparator path stays short
    always_comb begin
        if (thr_if.mode == DPRD_MODE_HIGH_BASE) begin
            thr_nxt = DPRD_BASE_M7 + {2'h0, thr_if.trim};
        end else begin
            thr_nxt = DPRD_BASE_STD + {2'h0, thr_if.trim};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            thr_r <= DPRD_BASE_STD;
        end else begin
            thr_r <= thr_nxt;
        end
    end

    assign thr_if.thr = thr_r;
endmodule // dprd_thr_calc

// ===== logic/dprd_divider.sv
`timescale 1ns/1ps
// Behaviour
// - trim affects display pulses only, not meter-constant
// - trim change leaves energy registers untouched
// - zero trim gives pulse per 25 LSBs
// - one accumulator LSB equals 0.4Wh default
// - threshold is 25 plus trim
// - mode 7 threshold is 250 plus trim
// - meter-constant pulses 1250 per kWh default
module dprd_divider
    import dprd_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // configuration
    input wire logic [DPRD_TRIM_W-1:0] i_display_rate_trim,
    input wire logic [2:0] i_mode,
    // energy accumulator LSB increments per quantity
    input wire logic [DPRD_NCH-1:0][DPRD_INC_W-1:0] i_lsb_inc,
    // meter-constant pulses passed through untouched by trim
    input wire logic [DPRD_NCH-1:0] i_mc_pulse,
    // outputs
    output logic [DPRD_NCH-1:0] o_disp_pulse,
    output logic [DPRD_NCH-1:0] o_mc_pulse
);
    ////////////////////////////////////////////////////////////////////////////
    // threshold
    dprd_thr_if thr_if ();
    logic [DPRD_CNT_W-1:0] thr;

    assign thr_if.trim = i_display_rate_trim;
    assign thr_if.mode = i_mode;
    assign thr = thr_if.thr;

    dprd_thr_calc u_thr (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .thr_if(thr_if)
    );

    ////////////////////////////////////////////////////////////////////////////
    // energy scale: one increment unit is one accumulator LSB, worth 0.4Wh
    // at default full scale and clock; the divider never sees that value, so
    // a changed full scale moves the energy per pulse, not the LSB count
    // limitation: meter-constant pulses arrive ready made from the energy
    // core at their own rate, so this block only re-times them by one cycle
    // trade-off: a one-cycle output delay buys outputs straight from flops

    ////////////////////////////////////////////////////////////////////////////
    // per-quantity counters; they only see LSB increments, never the
    // accumulator contents, so trim cannot disturb measurement data
    logic [DPRD_NCH-1:0][DPRD_CNT_W-1:0] cnt_r;
    logic [DPRD_NCH-1:0][DPRD_CNT_W-1:0] cnt_nxt;
    logic [DPRD_NCH-1:0] disp_r;
    logic [DPRD_NCH-1:0] disp_nxt;
    logic [DPRD_NCH-1:0] mc_r;

    genvar g;
    generate
        for (g = 0; g < DPRD_NCH; g++) begin : g_ch
            logic [DPRD_CNT_W:0] sum;
            // widened sum avoids wrap at max threshold plus increment
            always_comb begin
                sum = {1'b0, cnt_r[g]} + {{(DPRD_CNT_W+1-DPRD_INC_W){1'b0}}, i_lsb_inc[g]};
                if (sum >= {1'b0, thr}) begin
                    cnt_nxt[g] = DPRD_CNT_W'(sum - {1'b0, thr});
                    disp_nxt[g] = 1'b1;
                end else begin
                    cnt_nxt[g] = sum[DPRD_CNT_W-1:0];
                    disp_nxt[g] = 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r <= '0;
            disp_r <= '0;
            mc_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            disp_r <= disp_nxt;
            mc_r <= i_mc_pulse;
        end
    end

    assign o_disp_pulse = disp_r;
    assign o_mc_pulse = mc_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_MC_PASS: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 !$past(i_rst) |-> o_mc_pulse == $past(i_mc_pulse))
        else $error("meter-constant pulse altered");
    AST_THR_STD: assert property (@(posedge i_clk) disable iff (i_rst)
        i_mode != DPRD_MODE_HIGH_BASE ##1 !$past(i_rst) |->
        thr == DPRD_BASE_STD + {2'h0, $past(i_display_rate_trim)})
        else $error("standard threshold wrong");
    AST_THR_M7: assert property (@(posedge i_clk) disable iff (i_rst)
        i_mode == DPRD_MODE_HIGH_BASE ##1 !$past(i_rst) |->
        thr == DPRD_BASE_M7 + {2'h0, $past(i_display_rate_trim)})
        else $error("mode 7 threshold wrong");
    AST_CNT_BELOW: assert property (@(posedge i_clk) disable iff (i_rst)
        cnt_r[0] < thr || $changed(thr))
        else $error("count left at or above threshold");
    AST_PULSE_CAUSE: assert property (@(posedge i_clk) disable iff (i_rst)
        o_disp_pulse[0] |-> $past(cnt_r[0]) + $past(i_lsb_inc[0]) >= $past(thr))
        else $error("display pulse without threshold");
    AST_NO_LOSS: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 !$past(i_rst) && !o_disp_pulse[1] |->
        cnt_r[1] == $past(cnt_r[1]) + $past(i_lsb_inc[1]))
        else $error("energy LSBs lost");
    AST_CARRY: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 !$past(i_rst) && o_disp_pulse[2] |->
        cnt_r[2] == $past(cnt_r[2]) + $past(i_lsb_inc[2]) - $past(thr))
        else $error("carry wrong");
    AST_ISOL: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 !$past(i_rst) && !o_disp_pulse[3] && $past(i_lsb_inc[3]) == '0 |->
        cnt_r[3] == $past(cnt_r[3]))
        else $error("count moved without energy");

    // reset leaves both pulse outputs low, so the display counter outside
    // never sees a stray count when the block comes out of reset
    AST_RST_QUIET: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_rst) |-> o_disp_pulse == '0 && o_mc_pulse == '0)
        else $error("outputs active right after reset");

    // every count empty and the threshold at its standard base after reset
    AST_RST_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_rst) |-> cnt_r == '0 && thr == DPRD_BASE_STD)
        else $error("count or threshold not cleared by reset");

    // whatever trim and mode, the threshold stays between the standard base
    // and the high base plus a full trim byte
    AST_THR_RANGE: assert property (@(posedge i_clk) disable iff (i_rst)
        thr >= DPRD_BASE_STD && thr <= DPRD_BASE_M7 + {2'h0, {DPRD_TRIM_W{1'b1}}})
        else $error("threshold outside its range");

    // a trim step must never disturb the meter-constant lane
    AST_MC_TRIM: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 !$past(i_rst) && $past(i_display_rate_trim) != $past(i_display_rate_trim, 2) |->
        o_mc_pulse == $past(i_mc_pulse))
        else $error("meter-constant pulse moved by trim");

    // a trim step keeps the running count; only the threshold moves
    AST_TRIM_KEEP: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 !$past(i_rst) && $past(i_display_rate_trim) != $past(i_display_rate_trim, 2)
        && !o_disp_pulse[0] |-> cnt_r[0] == $past(cnt_r[0]) + $past(i_lsb_inc[0]))
        else $error("count disturbed by trim change");

    ////////////////////////////////////////////////////////////////////////////
    // starvation watch: while energy arrives every cycle the count grows by
    // at least one LSB a cycle, so a pulse is due within one full threshold;
    // the limit sits 20 cycles above the largest threshold that can be set
    localparam logic [DPRD_CNT_W-1:0] WAIT_LIM = DPRD_BASE_M7 + DPRD_BASE_M7 + DPRD_BASE_STD;
    logic [DPRD_NCH-1:0][DPRD_CNT_W-1:0] wait_r;
    logic [DPRD_NCH-1:0][DPRD_CNT_W-1:0] wait_nxt;

    // every billing quantity obeys the same divider law; all lanes are
    // checked alike so a fault in one lane of the loop cannot hide
    generate
        for (g = 0; g < DPRD_NCH; g++) begin : g_chk
            // cleared by a pulse or an idle cycle, else one more cycle
            always_comb begin
                if (o_disp_pulse[g] || i_lsb_inc[g] == '0) begin
                    wait_nxt[g] = '0;
                end else begin
                    wait_nxt[g] = wait_r[g] + 10'h001;
                end
            end

            // a pulse only once the running sum has reached the threshold
            AST_LANE_REACH: assert property (@(posedge i_clk) disable iff (i_rst)
                ##1 !$past(i_rst) && o_disp_pulse[g] |->
                $past(cnt_r[g]) + $past(i_lsb_inc[g]) >= $past(thr))
                else $error("lane pulse below threshold");

            // and never a missed pulse once it has
            AST_LANE_MISS: assert property (@(posedge i_clk) disable iff (i_rst)
                ##1 !$past(i_rst) && !o_disp_pulse[g] |->
                $past(cnt_r[g]) + $past(i_lsb_inc[g]) < $past(thr))
                else $error("lane pulse missed");

            // the excess over the threshold is kept, not dropped
            AST_LANE_CARRY: assert property (@(posedge i_clk) disable iff (i_rst)
                ##1 !$past(i_rst) && o_disp_pulse[g] |->
                cnt_r[g] == $past(cnt_r[g]) + $past(i_lsb_inc[g]) - $past(thr))
                else $error("lane carry wrong");

            // below the threshold every LSB lands in the count
            AST_LANE_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
                ##1 !$past(i_rst) && !o_disp_pulse[g] |->
                cnt_r[g] == $past(cnt_r[g]) + $past(i_lsb_inc[g]))
                else $error("lane lost LSBs");

            // steady energy must keep pulses coming
            AST_LANE_WAIT: assert property (@(posedge i_clk) disable iff (i_rst)
                wait_r[g] < WAIT_LIM)
                else $error("lane starved of pulses");
        end
    endgenerate

    // helper state for the starvation watch only; no output depends on it
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wait_r <= '0;
        end else begin
            wait_r <= wait_nxt;
        end
    end

    COV_PULSE: cover property (@(posedge i_clk) o_disp_pulse[0]);
    COV_M7: cover property (@(posedge i_clk) i_mode == DPRD_MODE_HIGH_BASE ##1 o_disp_pulse[2]);
    COV_MC: cover property (@(posedge i_clk) o_mc_pulse[1]);
    COV_CARRY: cover property (@(posedge i_clk) o_disp_pulse[0] && cnt_r[0] != '0);
    COV_TRIM_CHG: cover property (@(posedge i_clk) disable iff (i_rst)
        $changed(i_display_rate_trim));
endmodule // dprd_divider

// ===== testbench/dprd_disp_counter.sv
`timescale 1ns/1ps
// external display counter: one count per pulse seen at a clock edge
module dprd_disp_counter
    import dprd_pkg::*;
(
    // clock and clear
    input wire logic i_clk,
    input wire logic i_clr,
    // pulses in, tallies out
    input wire logic [DPRD_NCH-1:0] i_pulse,
    output logic [DPRD_NCH-1:0][15:0] o_tally
);
    // 16-bit tallies, plenty for the short cases run here
    always_ff @(posedge i_clk) begin
        for (int c = 0; c < DPRD_NCH; c++) begin
            o_tally[c] <= i_clr ? 16'h0000 : o_tally[c] + 16'(i_pulse[c]);
        end
    end
endmodule // dprd_disp_counter

// ===== testbench/display_pulse_rate_divider_tb.sv
`timescale 1ns/1ps
module display_pulse_rate_divider_tb;
    import dprd_pkg::*;
    // trim, mode, increment (halved per channel), edges, pulses ch0..ch3
    int rows [6][8] = '{'{0, 0, 1, 25, 1, 0, 0, 0}, '{0, 0, 1, 24, 0, 0, 0, 0},
        '{5, 0, 6, 40, 8, 4, 1, 0}, '{255, 3, 15, 38, 2, 0, 0, 0},
        '{0, 7, 15, 50, 3, 1, 0, 0}, '{10, 7, 13, 20, 1, 0, 0, 0}};
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [DPRD_TRIM_W-1:0] trim = 8'h00;
    logic [2:0] mode = 3'h0;
    logic [DPRD_NCH-1:0][DPRD_INC_W-1:0] inc = '0;
    logic [DPRD_NCH-1:0] mc_in = 4'h0;
    logic [DPRD_NCH-1:0] disp, mc_out, seen;
    logic [DPRD_NCH-1:0][15:0] tally;
    int err_total = 0;
    int n_checks = 0;
    // 20 MHz system clock
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    dprd_divider u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_display_rate_trim(trim),
        .i_mode(mode), .i_lsb_inc(inc), .i_mc_pulse(mc_in), .o_disp_pulse(disp),
        .o_mc_pulse(mc_out));
    // cleared with the divider so every case starts from zero
    dprd_disp_counter u_cnt (.i_clk(i_clk), .i_clr(i_rst), .i_pulse(disp), .o_tally(tally));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // meter-constant path checked every cycle, whatever the trim
    task automatic step(input int n, input logic [DPRD_INC_W-1:0] k);
        repeat (n) begin
            @(posedge i_clk);
            seen = mc_in;
            mc_in <= seen + 4'h3;
            for (int c = 0; c < DPRD_NCH; c++) begin
                inc[c] <= k >> c;
            end
            #10 check(16'(mc_out), 16'(seen));
        end
    endtask
    task automatic restart(input int t, input int m);
        @(posedge i_clk);
        i_rst <= 1'b1;
        trim <= 8'(t);
        mode <= 3'(m);
        inc <= '0;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        #2000000;
        err_total++;
        conclude();
    end
    initial begin
        foreach (rows[r]) begin
            restart(rows[r][0], rows[r][1]);
            step(rows[r][3], 4'(rows[r][2]));
            step(3, 4'h0);
            for (int c = 0; c < DPRD_NCH; c++) begin
                check(tally[c], 16'(rows[r][4 + c]));
            end
        end
        // trim raised mid-count: old threshold would give two pulses
        restart(0, 0);
        step(20, 4'h1);
        @(posedge i_clk);
        trim <= 8'h05;
        step(29, 4'h1);
        step(3, 4'h0);
        check(tally[0], 16'h0001);
        // reset in mid-count: outputs quiet, partial count thrown away
        restart(0, 0);
        step(20, 4'h1);
        restart(0, 0);
        #10;
        check(16'(disp), 16'h0000);
        check(16'(mc_out), 16'h0000);
        step(24, 4'h1);
        step(3, 4'h0);
        check(tally[0], 16'h0000);
        step(1, 4'h1);
        step(3, 4'h0);
        check(tally[0], 16'h0001);
        conclude();
    end
endmodule // display_pulse_rate_divider_tb
